// File: core/lba_host.sv
// Local bus master: reset driver and single-access sequencer for MAC port
// How it works
// - Direct wiring without wait states limits local clock to 11 MHz.
// - Direct wiring reaches 20 MHz with data-phase wait states only.
// - Master stretches address phase with wait states for the adapter.
// - Latch pulse over 20 ns; address held 10 ns beyond it.
// - Data-phase wait states suit MAC timing, same for read and write.
// - Only single reads or writes; window is non-prefetchable memory.
// - Bursts unsupported and kept off.
// - Each MAC has its own chip select and base space.
// - Region descriptor values per local clock are recommended.
// - MAC master reset comes from this logic, not the bridge.
// - Master reset held low at least 1 ms, requests stretched to it.
`timescale 1ns/100ps
module lba_host #(
  parameter int unsigned RST_LOW_CYC = lba_pkg::RST_LOW_CYC,
  parameter int unsigned SETTLE_CYC = lba_pkg::SETTLE_CYC
) (
  input wire logic core_clk,  // 125 MHz clock
  input wire logic rst_n,  // Asynchronous reset, active low
  input wire logic reset_req,  // Pulse: restart MAC master reset
  input wire logic cmd_valid,  // Access request
  input wire logic cmd_write,  // 1 write, 0 read
  input wire logic cmd_chip,  // Which MAC select
  input wire logic [lba_pkg::AD_W-1:0] cmd_addr,  // Access address
  input wire logic [lba_pkg::AD_W-1:0] cmd_wdata,  // Write data
  output logic cmd_ready,  // Request is taken when high
  output logic rsp_valid,  // One-cycle pulse: access done
  output logic [lba_pkg::AD_W-1:0] rsp_rdata,  // Read data
  output logic mac_ready,  // MAC out of reset and settled
  output logic local_bus_clock,  // Generated local bus clock
  output logic sync_addr_strobe_n,  // Address strobe, one local cycle
  output logic read_strobe_n,  // Read strobe
  output logic write_strobe_n,  // Write strobe
  output logic [lba_pkg::CS_W-1:0] chip_sel_n,  // One select per MAC
  output logic [lba_pkg::AD_W-1:0] ad_o,  // Muxed address/data out
  output logic ad_oe,  // Muxed bus drive enable
  input wire logic [lba_pkg::AD_W-1:0] ad_i,  // Muxed bus in
  output logic mac_master_reset_n  // MAC master reset
);
  // ==========================================================
  // Reset release and input sync
  // ==========================================================
  logic [1:0] rst_sync_r;
  logic srst_n;
  logic [lba_pkg::AD_W-1:0] ad_s1_r;
  logic [lba_pkg::AD_W-1:0] ad_s2_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_r[1];

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      ad_s1_r <= '0;
      ad_s2_r <= '0;
    end else begin
      ad_s1_r <= ad_i;
      ad_s2_r <= ad_s1_r;
    end
  end

  // ==========================================================
  // Local bus clock divider
  // ==========================================================
  // Local clock is 31.25 MHz, above the direct-wiring limits, so the
  // latch adapter is assumed on the bus.
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic local_bus_clock_r;
  logic step;

  assign div_nxt = div_r + 2'h1;
  // Bus outputs change as the local clock falls
  assign step = (div_r == lba_pkg::LOCAL_BUS_CLOCK_DIV_LAST);

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      div_r <= 2'h0;
      local_bus_clock_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      local_bus_clock_r <= (div_nxt >= lba_pkg::LOCAL_BUS_CLOCK_HIGH_FROM);
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  lba_pkg::lba_state_t state_r;
  lba_pkg::lba_state_t state_nxt;
  logic [lba_pkg::CNT_W-1:0] tmr_r;
  logic [lba_pkg::CNT_W-1:0] tmr_nxt;
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;
  logic pend_r;
  logic wr_r;
  logic chip_r;
  logic [lba_pkg::AD_W-1:0] addr_r;
  logic [lba_pkg::AD_W-1:0] wdata_r;
  logic [lba_pkg::AD_W-1:0] rdata_r;
  logic ready_r;
  logic rsp_r;
  logic mac_rdy_r;
  logic ads_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic [lba_pkg::CS_W-1:0] cs_n_r;
  logic [lba_pkg::AD_W-1:0] ad_o_r;
  logic ad_oe_r;
  logic rst_out_n_r;
  logic take;
  logic tmr_done;
  logic wait_done;
  logic [lba_pkg::CS_W-1:0] cs_sel_n;

  localparam logic [lba_pkg::CNT_W-1:0] RST_END =
    lba_pkg::CNT_W'(RST_LOW_CYC - 1);
  localparam logic [lba_pkg::CNT_W-1:0] SETTLE_END =
    lba_pkg::CNT_W'(SETTLE_CYC - 1);

  assign take = cmd_valid && ready_r;
  assign wait_done = (wait_r == 4'h0);
  assign tmr_done = (state_r == lba_pkg::ST_RESET) ? (tmr_r == RST_END) :
                    (tmr_r == SETTLE_END);
  // One select per MAC, each with its own space.
  assign cs_sel_n = chip_r ? 2'b01 : 2'b10;

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + lba_pkg::CNT_W'(1);
    wait_nxt = wait_r;
    case (state_r)
      lba_pkg::ST_RESET: begin
        // Master reset held for the full low time.
        if (tmr_done) begin
          state_nxt = lba_pkg::ST_SETTLE;
          tmr_nxt = '0;
        end
      end
      lba_pkg::ST_SETTLE: begin
        // No access until the MAC's internal timer ends.
        if (tmr_done) begin
          state_nxt = lba_pkg::ST_IDLE;
          tmr_nxt = '0;
        end
      end
      lba_pkg::ST_IDLE: begin
        tmr_nxt = '0;
        if (pend_r && step) begin
          state_nxt = lba_pkg::ST_ADDR;
          wait_nxt = lba_pkg::ADDR_WAIT;
        end
      end
      lba_pkg::ST_ADDR: begin
        // Address phase stretched so latch pulse and tail fit.
        tmr_nxt = '0;
        if (step) begin
          if (wait_done) begin
            state_nxt = lba_pkg::ST_DATA;
            wait_nxt = lba_pkg::DATA_WAIT;
          end else begin
            wait_nxt = wait_r - 4'h1;
          end
        end
      end
      lba_pkg::ST_DATA: begin
        // Same data wait for reads and writes.
        tmr_nxt = '0;
        if (step) begin
          if (wait_done) begin
            state_nxt = lba_pkg::ST_IDLE;
          end else begin
            wait_nxt = wait_r - 4'h1;
          end
        end
      end
      default: begin
        state_nxt = lba_pkg::ST_RESET;
        tmr_nxt = '0;
      end
    endcase
    if (reset_req) begin
      state_nxt = lba_pkg::ST_RESET;
      tmr_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      state_r <= lba_pkg::ST_RESET;
      tmr_r <= '0;
      wait_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Request capture: one single access at a time, never a burst
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      chip_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      if (take) begin
        pend_r <= 1'b1;
        wr_r <= cmd_write;
        chip_r <= cmd_chip;
        addr_r <= cmd_addr;
        wdata_r <= cmd_wdata;
      end else if (state_r != lba_pkg::ST_IDLE) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Status and answer
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      ready_r <= 1'b0;
      rsp_r <= 1'b0;
      rdata_r <= '0;
      mac_rdy_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == lba_pkg::ST_IDLE) && !pend_r && !take &&
                 !reset_req;
      rsp_r <= (state_r == lba_pkg::ST_DATA) && step && wait_done;
      if ((state_r == lba_pkg::ST_DATA) && step && wait_done && !wr_r) begin
        rdata_r <= ad_s2_r;
      end
      mac_rdy_r <= (state_nxt != lba_pkg::ST_RESET) &&
                   (state_nxt != lba_pkg::ST_SETTLE);
    end
  end

  // ==========================================================
  // Bus pins
  // ==========================================================
  always_ff @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      ads_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      cs_n_r <= '1;
      ad_o_r <= '0;
      ad_oe_r <= 1'b0;
      rst_out_n_r <= 1'b0;
    end else begin
      rst_out_n_r <= (state_nxt != lba_pkg::ST_RESET);
      if (step) begin
        // Strobe for one local cycle; adapter forms latch from it.
        ads_n_r <= !(state_nxt == lba_pkg::ST_ADDR &&
                     state_r == lba_pkg::ST_IDLE);
        rd_n_r <= !(state_nxt == lba_pkg::ST_DATA && !wr_r);
        wr_n_r <= !(state_nxt == lba_pkg::ST_DATA && wr_r);
        cs_n_r <= (state_nxt == lba_pkg::ST_ADDR ||
                   state_nxt == lba_pkg::ST_DATA) ? cs_sel_n : '1;
        ad_o_r <= (state_nxt == lba_pkg::ST_DATA) ? wdata_r : addr_r;
        ad_oe_r <= (state_nxt == lba_pkg::ST_ADDR) ||
                   (state_nxt == lba_pkg::ST_DATA && wr_r);
      end
    end
  end

  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign mac_ready = mac_rdy_r;
  assign local_bus_clock = local_bus_clock_r;
  assign sync_addr_strobe_n = ads_n_r;
  assign read_strobe_n = rd_n_r;
  assign write_strobe_n = wr_n_r;
  assign chip_sel_n = cs_n_r;
  assign ad_o = ad_o_r;
  assign ad_oe = ad_oe_r;
  assign mac_master_reset_n = rst_out_n_r;
endmodule : lba_host

// File: core/lba_pkg.sv
// Constants for the local bus master that drives the latch adapter and MAC
package lba_pkg;
  // ==========================================================
  // Clock and local bus clock
  // ==========================================================
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam logic [1:0] LOCAL_BUS_CLOCK_DIV_LAST = 2'h3;  // Local clock = core / 4
  localparam logic [1:0] LOCAL_BUS_CLOCK_HIGH_FROM = 2'h2;
  localparam int unsigned LOCAL_BUS_CLOCK_MHZ = CORE_CLK_MHZ / 4;
  // ==========================================================
  // Bus widths and timing
  // ==========================================================
  localparam int unsigned AD_W = 16;
  localparam int unsigned CS_W = 2;
  localparam int unsigned CNT_W = 24;
  // Local cycles of the address phase beyond the strobe cycle
  localparam logic [3:0] ADDR_WAIT = 4'h2;
  // Local cycles of the data phase beyond its first cycle, same for read and write
  localparam logic [3:0] DATA_WAIT = 4'h3;
  // Latch pulse must exceed this; address holds this much longer
  localparam int unsigned LATCH_MIN_NS = 20;
  localparam int unsigned ADDR_TAIL_NS = 10;
  // MAC master reset low time and digital settle time
  localparam int unsigned RST_LOW_US = 1000;
  localparam int unsigned SETTLE_US = 10000;
  localparam int unsigned RST_LOW_CYC = RST_LOW_US * CORE_CLK_MHZ;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CORE_CLK_MHZ;
  // ==========================================================
  // Recommended bridge space region descriptor values
  // ==========================================================
  localparam logic [31:0] SPACE_REGION_DESCRIPTOR_10MHZ = 32'h40402000;
  localparam logic [31:0] SPACE_REGION_DESCRIPTOR_20MHZ = 32'h40502800;
  localparam logic [31:0] SPACE_REGION_DESCRIPTOR_40MHZ = 32'h40727900;
  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_SETTLE = 3'b001,
    ST_IDLE = 3'b010,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b100
  } lba_state_t;
endpackage : lba_pkg

// File: test/lba_host_checker.sv
// Pin-level checker for the local bus master
`timescale 1ns/100ps
module lba_host_checker #(
  parameter int unsigned RST_LOW_CYC = 20,
  parameter int unsigned SETTLE_CYC = 40
) (
  input wire logic core_clk,  // Clock
  input wire logic rst_n,  // Reset, active low
  input wire logic rsp_valid,  // Access done
  input wire logic sync_addr_strobe_n,  // Address strobe
  input wire logic read_strobe_n,  // Read strobe
  input wire logic write_strobe_n,  // Write strobe
  input wire logic [1:0] chip_sel_n,  // Selects
  input wire logic [15:0] ad_o,  // Bus out
  input wire logic ad_oe,  // Bus drive enable
  input wire logic mac_master_reset_n  // MAC master reset
);
  logic [31:0] low_cnt_r;
  logic [31:0] high_cnt_r;
  logic phase_off;
  // A MAC reset may cut a bus phase short, which is legal
  assign phase_off = !rst_n || !mac_master_reset_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 32'h0;
      high_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= mac_master_reset_n ? 32'h0 : low_cnt_r + 32'h1;
      high_cnt_r <= mac_master_reset_n ? high_cnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  strobe_len_a: assert property (@(posedge core_clk)
    disable iff (phase_off) $fell(sync_addr_strobe_n) |->
    !sync_addr_strobe_n [*4] ##1 sync_addr_strobe_n) else $error("strobe");
  addr_hold_a: assert property (@(posedge core_clk)
    disable iff (phase_off) $fell(sync_addr_strobe_n) |=>
    (ad_oe && $stable(ad_o) && read_strobe_n && write_strobe_n) [*8])
    else $error("address phase short");
  one_sel_a: assert property ($countones(~chip_sel_n) <= 1)
    else $error("two selects low");
  ads_sel_a: assert property (!sync_addr_strobe_n |-> chip_sel_n != 2'h3)
    else $error("strobe without select");
  rst_hold_a: assert property ($rose(mac_master_reset_n) |->
    low_cnt_r >= RST_LOW_CYC) else $error("reset too short");
  settle_a: assert property (!sync_addr_strobe_n |->
    high_cnt_r >= SETTLE_CYC) else $error("access before settle");
  rd_len_a: assert property (@(posedge core_clk)
    disable iff (phase_off) $fell(read_strobe_n) |->
    ##16 $rose(read_strobe_n)) else $error("read phase length");
  wr_len_a: assert property (@(posedge core_clk)
    disable iff (phase_off) $fell(write_strobe_n) |->
    ##16 $rose(write_strobe_n)) else $error("write phase length");
  rsp_end_a: assert property (rsp_valid |->
    read_strobe_n && write_strobe_n && chip_sel_n == 2'h3 && !ad_oe &&
    !($past(read_strobe_n) && $past(write_strobe_n)))
    else $error("answer without closed data phase");
  bus_dir_a: assert property ((!write_strobe_n |-> ad_oe) and
    (!read_strobe_n |-> !ad_oe)) else $error("bus direction");
  cover property ($fell(read_strobe_n));
  cover property ($fell(write_strobe_n));
  cover property ($fell(mac_master_reset_n));
endmodule : lba_host_checker
bind lba_host lba_host_checker #(.RST_LOW_CYC(RST_LOW_CYC),
  .SETTLE_CYC(SETTLE_CYC)) u_lba_host_checker (.core_clk, .rst_n,
  .rsp_valid, .sync_addr_strobe_n, .read_strobe_n, .write_strobe_n,
  .chip_sel_n, .ad_o, .ad_oe, .mac_master_reset_n);

// File: test/lba_mac_model.sv
// Behavioural MAC control port behind its address-latch adapter
`timescale 1ns/100ps
module lba_mac_model (
  input wire logic local_bus_clock,  // Local bus clock
  input wire logic sync_addr_strobe_n,  // Address strobe
  input wire logic read_strobe_n,  // Read strobe
  input wire logic write_strobe_n,  // Write strobe
  input wire logic [1:0] chip_sel_n,  // Selects
  input wire logic [15:0] ad_o,  // Bus from master
  input wire logic mac_master_reset_n,  // Master reset
  output logic [15:0] ad_i  // Bus to master
);
  logic [15:0] mem_r [0:31];
  logic [4:0] addr_r = 5'h00;
  logic [15:0] last_r = 16'h0000;
  wire sel = chip_sel_n != 2'h3;
  wire rd = !read_strobe_n && sel;
  // Latch taken from the stretched address phase, as the fast-clock
  // region descriptor setting provides.
  always @(posedge local_bus_clock or negedge mac_master_reset_n) begin
    if (!mac_master_reset_n) begin
      for (int i = 0; i < 32; i++) mem_r[i] <= 16'h0000;
    end else begin
      if (!sync_addr_strobe_n && sel) addr_r <= {~chip_sel_n[1], ad_o[3:0]};
      if (!write_strobe_n && sel) mem_r[addr_r] <= ad_o;
      if (rd) last_r <= mem_r[addr_r];
    end
  end
  // Released bus shows the inverse of the last word read
  assign ad_i = rd ? mem_r[addr_r] : ~last_r;
endmodule : lba_mac_model

// File: test/local_bus_ale_adapter_bench.sv
// Self-checking bench for the local bus master
`timescale 1ns/100ps
module local_bus_ale_adapter_bench;
  localparam int unsigned LOW = 20;
  localparam int unsigned SET = 40;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_req = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_chip = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_ready, rsp_valid, mac_ready, local_bus_clock, ad_oe;
  logic sync_addr_strobe_n, read_strobe_n, write_strobe_n;
  logic mac_master_reset_n;
  logic [1:0] chip_sel_n;
  logic [15:0] rsp_rdata, ad_o, ad_i;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  lba_host #(.RST_LOW_CYC(LOW), .SETTLE_CYC(SET)) u_lba_host (.core_clk,
    .rst_n, .reset_req, .cmd_valid, .cmd_write, .cmd_chip, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .mac_ready,
    .local_bus_clock, .sync_addr_strobe_n, .read_strobe_n,
    .write_strobe_n, .chip_sel_n, .ad_o, .ad_oe, .ad_i,
    .mac_master_reset_n);
  lba_mac_model u_lba_mac_model (.local_bus_clock, .sync_addr_strobe_n,
    .read_strobe_n, .write_strobe_n, .chip_sel_n, .ad_o,
    .mac_master_reset_n, .ad_i);
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic issue(input logic w, c, input logic [15:0] a, d);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_chip <= c;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask : issue
  task automatic await(output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    for (int n = 0; n < 80 && !ok; n++) begin
      @(negedge core_clk);
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        q = rsp_rdata;
      end
    end
  endtask : await
  task automatic t_rw();
    logic [15:0] q;
    logic ok;
    for (int i = 0; i < 4; i++) begin
      issue(1'b1, i[0], {12'h000, i[1] ? 4'hF : 4'h0}, 16'hA5C3 ^ i[15:0]);
      await(q, ok);
      check(ok, "write not answered");
    end
    for (int i = 0; i < 4; i++) begin
      issue(1'b0, i[0], {12'h000, i[1] ? 4'hF : 4'h0}, 16'h0000);
      await(q, ok);
      check(ok && q === (16'hA5C3 ^ i[15:0]), "read data wrong");
    end
    $display("test rw done");
  endtask : t_rw
  task automatic t_local_bus_clock();
    logic [7:0] seen;
    logic [7:0] want;
    int per;
    per = int'(lba_pkg::LOCAL_BUS_CLOCK_DIV_LAST) + 1;
    for (int k = 0; k < 8; k++) begin
      want[k] = (k % per) < (per - int'(lba_pkg::LOCAL_BUS_CLOCK_HIGH_FROM));
    end
    @(posedge local_bus_clock);
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk);
      seen[k] = local_bus_clock;
    end
    check(seen === want && lba_pkg::LOCAL_BUS_CLOCK_MHZ > 20, "local clock");
    $display("test local_bus_clock done");
  endtask : t_local_bus_clock
  task automatic t_rst();
    logic [15:0] q;
    logic ok;
    int n;
    int up;
    issue(1'b1, 1'b0, 16'h0000, 16'h1234);
    repeat (8) @(posedge core_clk);
    reset_req <= 1'b1;
    @(posedge core_clk);
    reset_req <= 1'b0;
    @(negedge core_clk);
    check(mac_master_reset_n === 1'b0 && mac_ready === 1'b0, "no reset");
    ok = 1'b0;
    n = 0;
    up = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
      end
      if (mac_master_reset_n === 1'b1 && up == 0) begin
        up = n;
      end
    end
    check(!ok, "aborted access answered");
    check(up == LOW, "reset low time");
    check(n == LOW + SET && mac_ready === 1'b1, "ready early");
    issue(1'b0, 1'b0, 16'h0000, 16'h0000);
    await(q, ok);
    check(ok && q === 16'h0000, "MAC not reset");
    $display("test reset done");
  endtask : t_rst
  task automatic conclude();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_rw();
    t_local_bus_clock();
    t_rst();
    conclude();
  end
endmodule : local_bus_ale_adapter_bench
